// ===== slfs_supervisor.sv
// Link fail supervisor: serial frame checks, watchdog, input deglitch,
// clock monitor, mode control and output steering.
// Assumes slave serial mode 0 (sample on rising sclk) and pins from other domains.
// Operation
// - Non-inverted watchdog toggle bit forces Fail
// - No valid frame within watchdog period forces Fail
// - Frame length not multiple of sixteen fails
// - Stuck input or lost supply seen as toggle
// - Communication fault sets flag in status seven
// - Flag held in Fail, cleared leaving Fail for Normal
// - Low pass filter on direct, fail, reset, clock
// - Fail and direct inputs deglitched on both edges
// - Long fail-force high raises request, enters Fail
// - Long direct input high drives its channel
// - Reset input deglitched on falling edge only
// - Clock deglitched; too fast clock means failure
// - Low frequency clock monitor starts at reset rise
// - Failed clock: channel control alone, else duty
// - Clock failure latched until gone and read
// - External switch follows channel six in Normal
// - External switch off in Sleep and Fail
// - In Fail channels follow filtered direct inputs
// - Fail-force input state readable in status seven
`timescale 1ns/1ns
module slfs_supervisor #(
  parameter int WD_SHORT_TICKS = slfs_pkg::WD_SHORT_TICKS,
  parameter int WD_LONG_TICKS = slfs_pkg::WD_LONG_TICKS,
  parameter int IN_DGL_TICKS = slfs_pkg::IN_DGL_TICKS,
  parameter int CLK_LOW_TICKS = slfs_pkg::CLK_LOW_TICKS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic chip_select_low_in,
  input wire logic mosi_in,
  input wire logic link_clock_in,
  input wire logic wake_reset_input_in,
  input wire logic fail_force_in,
  input wire logic [slfs_pkg::NUM_CH-1:0] direct_channel_input_in,
  input wire logic watchdog_period_select_in,
  input wire logic [slfs_pkg::NUM_CH-1:0] channel_control_signal_in,
  input wire logic [slfs_pkg::NUM_CH-1:0] pwm_in,
  output logic miso_out,
  output logic miso_oe_out,
  output logic [slfs_pkg::NUM_CH-1:0] channel_out,
  output logic external_switch_control_out,
  output logic fail_mode_out,
  output logic sleep_mode_out,
  output logic comm_failure_flag_out,
  output logic clock_fail_out,
  output logic filtered_fail_request_out
);

  // ************************************************
  // Tick divider and pin synchronisers
  // ************************************************
  logic [slfs_pkg::TICK_W-1:0] tick_cnt;
  logic [slfs_pkg::TICK_W-1:0] next_tick_cnt;
  logic tick;
  logic next_tick;
  logic [slfs_pkg::PIN_W-1:0] sync1;
  logic [slfs_pkg::PIN_W-1:0] sync2;
  logic [slfs_pkg::PIN_W-1:0] sync3;
  logic [slfs_pkg::PIN_W-1:0] pin_clean;
  logic [slfs_pkg::PIN_W-1:0] next_pin_clean;
  logic sclk_c;
  logic cs_c;
  logic mosi_c;
  logic lclk_c;
  logic wake_reset_input_c;
  logic limp_c;
  logic [slfs_pkg::NUM_CH-1:0] din_c;

  always_comb begin
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 1'b1;
    if (tick_cnt == slfs_pkg::TICK_W'(slfs_pkg::TICK_CYCLES - 1)) begin
      next_tick_cnt = '0;
      next_tick = 1'b1;
    end
    // A bit moves only once the second and third stage agree
    next_pin_clean = (pin_clean & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tick_cnt <= '0;
      tick <= 1'b0;
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pin_clean <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
      sync1 <= {sclk_in, chip_select_low_in, mosi_in, link_clock_in,
                wake_reset_input_in, fail_force_in, direct_channel_input_in};
      sync2 <= sync1;
      sync3 <= sync2;
      pin_clean <= next_pin_clean;
    end
  end

  assign {sclk_c, cs_c, mosi_c, lclk_c, wake_reset_input_c, limp_c, din_c} = pin_clean;

  // ************************************************
  // Deglitchers
  // ************************************************
  logic filtered_fail_request;
  logic [slfs_pkg::NUM_CH-1:0] filtered_direct_input;
  logic wake_reset_input_f;
  logic lclk_f;

  slfs_deglitch #(.DGL_TICKS(IN_DGL_TICKS), .FALL_ONLY(1'b0)) u_dgl_fail (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
    .raw_in(limp_c), .filt_out(filtered_fail_request));

  for (genvar i = 0; i < slfs_pkg::NUM_CH; i++) begin : g_din
    slfs_deglitch #(.DGL_TICKS(IN_DGL_TICKS), .FALL_ONLY(1'b0)) u_dgl_din (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .raw_in(din_c[i]), .filt_out(filtered_direct_input[i]));
  end

  slfs_deglitch #(.DGL_TICKS(slfs_pkg::RST_DGL_TICKS), .FALL_ONLY(1'b1)) u_dgl_rst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
    .raw_in(wake_reset_input_c), .filt_out(wake_reset_input_f));

  // Too fast a clock never gets through, so the low limit catches it
  slfs_deglitch #(.DGL_TICKS(slfs_pkg::CLK_DGL_TICKS), .FALL_ONLY(1'b0)) u_dgl_clk (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
    .raw_in(lclk_c), .filt_out(lclk_f));

  // ************************************************
  // Serial frame engine
  // ************************************************
  slfs_pkg::slfs_mode_e mode;
  logic comm_failure_flag;
  logic clk_fail_latched;
  logic sclk_d;
  logic cs_d;
  logic any_bit;
  logic next_any_bit;
  logic [slfs_pkg::BIT_CNT_W-1:0] bit_cnt;
  logic [slfs_pkg::BIT_CNT_W-1:0] next_bit_cnt;
  logic [slfs_pkg::FRAME_W-1:0] rx_sr;
  logic [slfs_pkg::FRAME_W-1:0] next_rx_sr;
  logic [slfs_pkg::FRAME_W-1:0] tx_sr;
  logic [slfs_pkg::FRAME_W-1:0] next_tx_sr;
  logic [slfs_pkg::FRAME_W-1:0] stat7;
  logic cs_rise;

  assign cs_rise = cs_c && !cs_d;

  always_comb begin
    stat7 = '0;
    stat7[slfs_pkg::STAT7_COMM_FAIL_BIT] = comm_failure_flag;
    stat7[slfs_pkg::STAT7_FAIL_INPUT_BIT] = filtered_fail_request;
    stat7[slfs_pkg::STAT7_CLK_FAIL_BIT] = clk_fail_latched;
    stat7[slfs_pkg::STAT7_FAIL_MODE_BIT] = (mode == slfs_pkg::MODE_FAIL);
    next_any_bit = any_bit;
    next_bit_cnt = bit_cnt;
    next_rx_sr = rx_sr;
    next_tx_sr = tx_sr;
    if (!cs_c && cs_d) begin
      next_any_bit = 1'b0;
      next_bit_cnt = '0;
      next_tx_sr = stat7;
    end else if (!cs_c && sclk_c && !sclk_d) begin
      next_any_bit = 1'b1;
      next_bit_cnt = bit_cnt + 1'b1;
      next_rx_sr = {rx_sr[slfs_pkg::FRAME_W-2:0], mosi_c};
    end else if (!cs_c && !sclk_c && sclk_d) begin
      next_tx_sr = {tx_sr[slfs_pkg::FRAME_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sclk_d <= 1'b0;
      cs_d <= 1'b0;
      any_bit <= 1'b0;
      bit_cnt <= '0;
      rx_sr <= '0;
      tx_sr <= '0;
    end else begin
      sclk_d <= sclk_c;
      cs_d <= cs_c;
      any_bit <= next_any_bit;
      bit_cnt <= next_bit_cnt;
      rx_sr <= next_rx_sr;
      tx_sr <= next_tx_sr;
    end
  end

  // ************************************************
  // Watchdog, clock monitor and mode control
  // ************************************************
  slfs_pkg::slfs_mode_e next_mode;
  logic next_comm_failure_flag;
  logic next_clk_fail_latched;
  logic prev_wd;
  logic next_prev_wd;
  logic ch6_on;
  logic next_ch6_on;
  logic wake_reset_input_d;
  logic lclk_d;
  logic [slfs_pkg::CNT_W-1:0] wd_cnt;
  logic [slfs_pkg::CNT_W-1:0] next_wd_cnt;
  logic [slfs_pkg::CNT_W-1:0] clk_cnt;
  logic [slfs_pkg::CNT_W-1:0] next_clk_cnt;
  logic [slfs_pkg::CNT_W-1:0] wd_limit;
  logic frame_ok;
  logic len_err;
  logic toggle_err;
  logic good_frame;
  logic wd_timeout;
  logic comm_fault;
  logic qs1_read;
  logic clk_cond;

  always_comb begin
    wd_limit = watchdog_period_select_in ? slfs_pkg::CNT_W'(WD_LONG_TICKS)
                                         : slfs_pkg::CNT_W'(WD_SHORT_TICKS);
    frame_ok = cs_rise && any_bit && (bit_cnt == '0);
    len_err = cs_rise && any_bit && (bit_cnt != '0);
    // No separate stuck-input or supply check: both surface here
    toggle_err = frame_ok && (rx_sr[slfs_pkg::FRAME_WD_BIT] == prev_wd);
    good_frame = frame_ok && !toggle_err;
    wd_timeout = (mode == slfs_pkg::MODE_NORMAL) && tick
                 && (wd_cnt == wd_limit - 1'b1);
    comm_fault = (mode != slfs_pkg::MODE_SLEEP) && (len_err || toggle_err || wd_timeout);
    qs1_read = good_frame && rx_sr[slfs_pkg::FRAME_READ_BIT]
               && (rx_sr[slfs_pkg::FRAME_ADDR_MSB:slfs_pkg::FRAME_ADDR_LSB]
                   == slfs_pkg::ADDR_QUICK_STATUS_1);
    clk_cond = (clk_cnt >= slfs_pkg::CNT_W'(CLK_LOW_TICKS));
    next_prev_wd = frame_ok ? rx_sr[slfs_pkg::FRAME_WD_BIT] : prev_wd;
    next_ch6_on = ch6_on;
    if (good_frame && !rx_sr[slfs_pkg::FRAME_READ_BIT]
        && (rx_sr[slfs_pkg::FRAME_ADDR_MSB:slfs_pkg::FRAME_ADDR_LSB]
            == slfs_pkg::ADDR_INPUT_DATA)) begin
      next_ch6_on = rx_sr[slfs_pkg::FRAME_CH6_BIT];
    end
    next_wd_cnt = wd_cnt + 1'b1;
    if (mode != slfs_pkg::MODE_NORMAL || good_frame || wd_timeout) begin
      next_wd_cnt = '0;
    end else if (!tick) begin
      next_wd_cnt = wd_cnt;
    end
    next_clk_cnt = clk_cnt;
    if (!wake_reset_input_f || (wake_reset_input_f && !wake_reset_input_d) || (lclk_f && !lclk_d)) begin
      next_clk_cnt = '0;
    end else if (tick && !clk_cond) begin
      next_clk_cnt = clk_cnt + 1'b1;
    end
    next_clk_fail_latched = clk_cond || (clk_fail_latched && !qs1_read);
    next_mode = mode;
    unique case (mode)
      slfs_pkg::MODE_SLEEP: begin
        if (wake_reset_input_f) begin
          next_mode = slfs_pkg::MODE_NORMAL;
        end
      end
      slfs_pkg::MODE_NORMAL: begin
        if (comm_fault || filtered_fail_request) begin
          next_mode = slfs_pkg::MODE_FAIL;
        end
      end
      slfs_pkg::MODE_FAIL: begin
        if (good_frame && !filtered_fail_request && !comm_fault) begin
          next_mode = slfs_pkg::MODE_NORMAL;
        end
      end
    endcase
    if (!wake_reset_input_f) begin
      next_mode = slfs_pkg::MODE_SLEEP;
    end
    next_comm_failure_flag = comm_failure_flag;
    if (mode == slfs_pkg::MODE_FAIL && next_mode == slfs_pkg::MODE_NORMAL) begin
      next_comm_failure_flag = 1'b0;
    end
    if (comm_fault) begin
      next_comm_failure_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode <= slfs_pkg::MODE_SLEEP;
      comm_failure_flag <= 1'b0;
      clk_fail_latched <= 1'b0;
      prev_wd <= 1'b0;
      ch6_on <= 1'b0;
      wake_reset_input_d <= 1'b0;
      lclk_d <= 1'b0;
      wd_cnt <= '0;
      clk_cnt <= '0;
    end else begin
      mode <= next_mode;
      comm_failure_flag <= next_comm_failure_flag;
      clk_fail_latched <= next_clk_fail_latched;
      prev_wd <= next_prev_wd;
      ch6_on <= next_ch6_on;
      wake_reset_input_d <= wake_reset_input_f;
      lclk_d <= lclk_f;
      wd_cnt <= next_wd_cnt;
      clk_cnt <= next_clk_cnt;
    end
  end

  // ************************************************
  // Output steering
  // ************************************************
  logic [slfs_pkg::NUM_CH-1:0] next_channel;

  always_comb begin
    unique case (mode)
      slfs_pkg::MODE_FAIL: next_channel = filtered_direct_input;
      slfs_pkg::MODE_NORMAL: next_channel = clk_cond ? channel_control_signal_in
                                  : (channel_control_signal_in & pwm_in);
      slfs_pkg::MODE_SLEEP: next_channel = '0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      channel_out <= '0;
      external_switch_control_out <= 1'b0;
      miso_out <= 1'b0;
      miso_oe_out <= 1'b0;
      fail_mode_out <= 1'b0;
      sleep_mode_out <= 1'b1;
      comm_failure_flag_out <= 1'b0;
      clock_fail_out <= 1'b0;
      filtered_fail_request_out <= 1'b0;
    end else begin
      channel_out <= next_channel;
      external_switch_control_out <= (mode == slfs_pkg::MODE_NORMAL) && ch6_on;
      miso_out <= tx_sr[slfs_pkg::FRAME_W-1];
      miso_oe_out <= !cs_c;
      fail_mode_out <= (mode == slfs_pkg::MODE_FAIL);
      sleep_mode_out <= (mode == slfs_pkg::MODE_SLEEP);
      comm_failure_flag_out <= comm_failure_flag;
      clock_fail_out <= clk_fail_latched;
      filtered_fail_request_out <= filtered_fail_request;
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  a_toggle_fault: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode == slfs_pkg::MODE_NORMAL && toggle_err && wake_reset_input_f)
    |=> (mode == slfs_pkg::MODE_FAIL && comm_failure_flag))
    else $error("missing toggle did not force fail");
  a_length_fault: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode == slfs_pkg::MODE_NORMAL && len_err && wake_reset_input_f) |=> mode == slfs_pkg::MODE_FAIL)
    else $error("length error did not force fail");
  a_wd_timeout: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wd_timeout && wake_reset_input_f) |=> (mode == slfs_pkg::MODE_FAIL && wd_cnt == '0))
    else $error("watchdog timeout did not force fail");
  a_wd_restart: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (good_frame && mode == slfs_pkg::MODE_NORMAL) |=> wd_cnt == '0)
    else $error("good frame did not restart watchdog");
  a_flag_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ($past(mode) == slfs_pkg::MODE_FAIL && mode == slfs_pkg::MODE_FAIL
     && $past(comm_failure_flag)) |-> comm_failure_flag)
    else $error("flag dropped while in fail");
  a_flag_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ($past(mode) == slfs_pkg::MODE_FAIL && mode == slfs_pkg::MODE_NORMAL)
    |-> !comm_failure_flag)
    else $error("flag not cleared leaving fail");
  a_ext_switch_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode != slfs_pkg::MODE_NORMAL) |=> !external_switch_control_out)
    else $error("external switch on outside normal");
  a_clk_fail_latch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (clk_fail_latched && !qs1_read) |=> clk_fail_latched)
    else $error("clock failure dropped without read");
  a_fail_request: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (filtered_fail_request && mode == slfs_pkg::MODE_NORMAL && wake_reset_input_f)
    |=> mode == slfs_pkg::MODE_FAIL)
    else $error("fail request did not enter fail");
  a_fail_direct: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode == slfs_pkg::MODE_FAIL) |=> channel_out == $past(filtered_direct_input))
    else $error("fail mode channel not from direct input");

endmodule

// ===== slfs_pkg.sv
// Constants, timing figures and types shared by the link fail supervisor.
// Assumes a single 100 MHz clock; all slow timing runs on a 1 us tick.
package slfs_pkg;

  // ************************************************
  // Clock and tick
  // ************************************************
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
  localparam int TICK_W = 7;

  // ************************************************
  // Timing figures and derived tick counts
  // ************************************************
  localparam int WD_SHORT_MS = 32;
  localparam int WD_LONG_MS = 128;
  localparam int WD_SHORT_TICKS = (WD_SHORT_MS * 1000) / TICK_US;
  localparam int WD_LONG_TICKS = (WD_LONG_MS * 1000) / TICK_US;
  localparam int IN_DGL_US = 200;
  localparam int IN_DGL_TICKS = IN_DGL_US / TICK_US;
  localparam int RST_DGL_US = 10;
  localparam int RST_DGL_TICKS = RST_DGL_US / TICK_US;
  localparam int CLK_DGL_US = 2;
  localparam int CLK_DGL_TICKS = CLK_DGL_US / TICK_US;
  localparam int CLK_LOW_HZ = 100;
  localparam int CLK_LOW_TICKS = 1000000 / (CLK_LOW_HZ * TICK_US);
  localparam int CNT_W = 17;
  localparam int DGL_W = 8;

  // ************************************************
  // Frame layout and status word
  // ************************************************
  localparam int FRAME_W = 16;
  localparam int BIT_CNT_W = 4;
  localparam int FRAME_WD_BIT = 15;
  localparam int FRAME_ADDR_MSB = 14;
  localparam int FRAME_ADDR_LSB = 12;
  localparam int FRAME_READ_BIT = 11;
  localparam int FRAME_CH6_BIT = 5;
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] ADDR_QUICK_STATUS_1 = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_INPUT_DATA = 3'h2;
  localparam int STAT7_COMM_FAIL_BIT = 15;
  localparam int STAT7_FAIL_INPUT_BIT = 14;
  localparam int STAT7_CLK_FAIL_BIT = 13;
  localparam int STAT7_FAIL_MODE_BIT = 12;
  localparam int NUM_CH = 4;
  localparam int PIN_W = 10;

  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_NORMAL,
    MODE_FAIL
  } slfs_mode_e;

endpackage

// ===== slfs_deglitch.sv
// One input deglitcher, symmetric or falling edge only.
// Assumes raw_in is already synchronised and tick_in is a one-cycle enable.
`timescale 1ns/1ns
module slfs_deglitch #(
  parameter int DGL_TICKS = 1,
  parameter bit FALL_ONLY = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire logic raw_in,
  output logic filt_out
);

  logic [slfs_pkg::DGL_W-1:0] cnt;
  logic [slfs_pkg::DGL_W-1:0] next_cnt;
  logic next_filt;

  // ************************************************
  // Filter
  // ************************************************
  // A change must persist for the full time (only a fall when FALL_ONLY); any bounce restarts it
  always_comb begin
    next_cnt = cnt;
    next_filt = filt_out;
    if (raw_in == filt_out) begin
      next_cnt = '0;
    end else if (FALL_ONLY && raw_in) begin
      next_filt = 1'b1;
      next_cnt = '0;
    end else if (tick_in) begin
      if (cnt == slfs_pkg::DGL_W'(DGL_TICKS - 1)) begin
        next_filt = raw_in;
        next_cnt = '0;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
      filt_out <= 1'b0;
    end else begin
      cnt <= next_cnt;
      filt_out <= next_filt;
    end
  end

  a_rise_passes: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (FALL_ONLY && raw_in && !filt_out) |=> filt_out)
    else $error("rising edge was delayed");
  a_short_pulse_held: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (raw_in != filt_out && !tick_in && !(FALL_ONLY && raw_in)) |=> $stable(filt_out))
    else $error("filter output changed without a tick");

endmodule

// ===== slfs_host_model.sv
// Host serial master model for the link supervisor bench.
// Assumes callers start on a falling clk edge; mode 0 frames, MSB first.
`timescale 1ns/1ns
module slfs_host_model (
  output logic sclk_out,
  output logic chip_select_low_out,
  output logic mosi_out,
  input wire logic miso_in
);
  logic [15:0] resp;

  initial begin
    sclk_out = 1'b0;
    chip_select_low_out = 1'b1;
    mosi_out = 1'b0;
    resp = 16'h0;
  end

  // ************************************************
  // Frame
  // ************************************************
  // Phases of 80 ns keep every sclk edge 8 cycles apart and off the sampling edge
  task automatic frame(input int nbits, input logic [31:0] word);
    int i;
    chip_select_low_out = 1'b0;
    #160;
    for (i = nbits - 1; i >= 0; i--) begin
      mosi_out = word[i];
      #80 sclk_out = 1'b1;
      resp = {resp[14:0], miso_in};
      #80 sclk_out = 1'b0;
    end
    #160 chip_select_low_out = 1'b1;
    // Released data line must not keep its last level
    mosi_out = ~mosi_out;
    #200;
  endtask
endmodule

// ===== tb.sv
// Self-checking bench for the link fail supervisor.
// Assumes the host model drives the serial pins; short tick counts set here.
`timescale 1ns/1ns
module tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic lk = 1'b0;
  logic wake = 1'b0;
  logic ff = 1'b0;
  logic watchdog_period_select = 1'b0;
  logic tg = 1'b0;
  logic [3:0] din = 4'h0;
  logic [3:0] ctrl = 4'h0;
  logic [3:0] pwm = 4'h0;
  logic [3:0] r;
  logic [3:0] chan;
  logic sclk, csn, mosi, miso, miso_oe, ext, failm, sleepm, cflag, ckf, ffr;
  int errors = 0;
  int checks_done = 0;
  int lk_half = 0;
  int halves[2] = '{0, 80};

  always #5 clk_in = ~clk_in;
  // Zero half period parks the link clock; fast rate is the 160 ns one
  always begin
    if (lk_half == 0) #53;
    else #(lk_half) lk = ~lk;
  end

  slfs_supervisor #(.WD_SHORT_TICKS(40), .WD_LONG_TICKS(80), .IN_DGL_TICKS(4),
    .CLK_LOW_TICKS(60)) slfs_supervisor_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .sclk_in(sclk), .chip_select_low_in(csn), .mosi_in(mosi), .link_clock_in(lk),
    .wake_reset_input_in(wake), .fail_force_in(ff), .direct_channel_input_in(din),
    .watchdog_period_select_in(watchdog_period_select), .channel_control_signal_in(ctrl),
    .pwm_in(pwm), .miso_out(miso), .miso_oe_out(miso_oe), .channel_out(chan),
    .external_switch_control_out(ext), .fail_mode_out(failm),
    .sleep_mode_out(sleepm), .comm_failure_flag_out(cflag),
    .clock_fail_out(ckf), .filtered_fail_request_out(ffr));

  slfs_host_model slfs_host_model_i (.sclk_out(sclk), .chip_select_low_out(csn),
    .mosi_out(mosi), .miso_in(miso));

  // ************************************************
  // Helpers
  // ************************************************
  task automatic chk_bit(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_vec(input string name, input logic [3:0] exp, input logic [3:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic us(input int n);
    repeat (n * 100) @(negedge clk_in);
  endtask

  function automatic logic [31:0] word(input logic t, input logic [2:0] a,
    input logic rd, input logic c6);
    word = {16'h0, t, a, rd, 5'h0, c6, 5'h0};
  endfunction

  task automatic send(input logic inv, input int n, input logic [2:0] a,
    input logic rd, input logic c6);
    if (inv) tg = ~tg;
    slfs_host_model_i.frame(n, word(tg, a, rd, c6));
    us(1);
  endtask

  // A length error never moves the toggle reference, so retry once
  task automatic recover(input logic ef);
    send(1'b1, 16, slfs_pkg::ADDR_INPUT_DATA, 1'b0, 1'b0);
    chk_bit("resp_comm_flag", ef, slfs_host_model_i.resp[15]);
    if (failm === 1'b1) send(1'b1, 16, slfs_pkg::ADDR_INPUT_DATA, 1'b0, 1'b0);
    chk_bit("fail_mode", 1'b0, failm);
    chk_bit("comm_flag", 1'b0, cflag);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ************************************************
  // Tests
  // ************************************************
  initial begin
    void'($urandom(74321));
    repeat (16) @(negedge clk_in);
    chk_bit("sleep_rst", 1'b1, sleepm);
    chk_vec("out_rst", 4'h0, {failm, cflag, ckf, ext});
    rst_n_in = 1'b1;
    wake = 1'b1;
    lk_half = 9000;
    us(1);
    chk_bit("sleep", 1'b0, sleepm);
    repeat (3) begin
      send(1'b1, 16, slfs_pkg::ADDR_INPUT_DATA, 1'b0, 1'b1);
      us(25);
      chk_bit("fail_mode", 1'b0, failm);
      chk_bit("ext_sw", 1'b1, ext);
    end
    us(45);
    chk_bit("fail_mode", 1'b1, failm);
    chk_bit("comm_flag", 1'b1, cflag);
    chk_bit("ext_sw", 1'b0, ext);
    recover(1'b1);
    watchdog_period_select = 1'b1;
    us(60);
    chk_bit("fail_mode", 1'b0, failm);
    us(30);
    chk_bit("fail_mode", 1'b1, failm);
    recover(1'b1);
    send(1'b0, 16, slfs_pkg::ADDR_INPUT_DATA, 1'b0, 1'b0);
    chk_bit("fail_mode", 1'b1, failm);
    recover(1'b1);
    repeat (2) begin
      send(1'b1, 1 + $urandom % 15 + 16 * ($urandom % 2), slfs_pkg::ADDR_INPUT_DATA,
        1'b0, 1'b0);
      chk_bit("fail_mode", 1'b1, failm);
      recover(1'b1);
    end
    send(1'b1, 32, slfs_pkg::ADDR_INPUT_DATA, 1'b0, 1'b0);
    chk_bit("fail_mode", 1'b0, failm);
    ff = 1'b1;
    us(2);
    ff = 1'b0;
    us(6);
    chk_bit("fail_req", 1'b0, ffr);
    r = 4'($urandom);
    din = r;
    ff = 1'b1;
    us(6);
    chk_bit("fail_req", 1'b1, ffr);
    chk_bit("fail_mode", 1'b1, failm);
    chk_vec("chan", r, chan);
    din = ~r;
    us(2);
    din = r;
    us(6);
    chk_vec("chan", r, chan);
    send(1'b1, 16, slfs_pkg::ADDR_INPUT_DATA, 1'b0, 1'b0);
    chk_bit("resp_fail_in", 1'b1, slfs_host_model_i.resp[14]);
    chk_bit("fail_mode", 1'b1, failm);
    ff = 1'b0;
    us(6);
    recover(1'b0);
    ctrl = 4'($urandom);
    pwm = 4'($urandom);
    foreach (halves[k]) begin
      send(1'b1, 16, slfs_pkg::ADDR_INPUT_DATA, 1'b0, 1'b0);
      lk_half = halves[k];
      us(75);
      chk_bit("clk_fail", 1'b1, ckf);
      chk_vec("chan", ctrl, chan);
      lk_half = 9000;
      send(1'b1, 16, slfs_pkg::ADDR_INPUT_DATA, 1'b0, 1'b0);
      us(25);
      chk_bit("clk_fail", 1'b1, ckf);
      send(1'b1, 16, slfs_pkg::ADDR_QUICK_STATUS_1, 1'b1, 1'b0);
      chk_bit("clk_fail", 1'b0, ckf);
      chk_vec("chan", ctrl & pwm, chan);
    end
    // Enable must rise inside the frame and drop once chip select is released
    fork
      send(1'b1, 16, slfs_pkg::ADDR_INPUT_DATA, 1'b0, 1'b1);
      begin
        us(1);
        chk_bit("miso_oe", 1'b1, miso_oe);
      end
    join
    chk_bit("miso_oe", 1'b0, miso_oe);
    wake = 1'b0;
    us(3);
    wake = 1'b1;
    us(1);
    chk_bit("sleep", 1'b0, sleepm);
    chk_bit("ext_sw", 1'b1, ext);
    wake = 1'b0;
    us(15);
    chk_bit("sleep", 1'b1, sleepm);
    chk_bit("ext_sw", 1'b0, ext);
    wake = 1'b1;
    us(1);
    chk_bit("sleep", 1'b0, sleepm);
    results;
  end

  // Whole sequence needs roughly 600 us
  initial begin
    #900000;
    errors++;
    results;
  end
endmodule
